/* design/tcc_pkg.sv */
// Constants for the timer compare/capture channel.
// Assumes a 32-bit APB master and word-indexed register addresses.
package tcc_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_COUNTER_VALUE = 16'h5422;
   localparam logic [15:0] IDX_CAPTURE_CONTROL = 16'h5424;
   localparam logic [15:0] IDX_MATCH_CAPTURE_A = 16'h5426;
   localparam logic [15:0] IDX_MATCH_B = 16'h5428;
   localparam logic [15:0] IDX_INTERRUPT_ENABLES = 16'h542A;
   localparam logic [15:0] IDX_INTERRUPT_FLAGS = 16'h542C;
   localparam int WORD_SHIFT = 2;

   // ----------------------------------------------------------------
   // Capture control field positions
   // ----------------------------------------------------------------
   localparam int CTL_EDGE_LSB = 6;
   localparam int CTL_WAVE_LSB = 4;
   localparam int CTL_POL_BIT = 1;
   localparam int CTL_FUNC_BIT = 0;

   // ----------------------------------------------------------------
   // Interrupt flag and enable bit positions (same layout)
   // ----------------------------------------------------------------
   localparam int IRQ_OVR_BIT = 4;
   localparam int IRQ_CAP_BIT = 2;
   localparam int IRQ_MB_BIT = 1;
   localparam int IRQ_MA_BIT = 0;
   localparam logic [15:0] IRQ_MASK = 16'h0017;

   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] WAVE_OFF = 2'h0;
   localparam logic [1:0] WAVE_SET_A_CLR_B = 2'h1;
   localparam logic [1:0] WAVE_TOGGLE_A = 2'h2;
   localparam logic [1:0] WAVE_TOGGLE_B = 2'h3;
   localparam logic FUNC_COMPARE = 1'h0;
   localparam logic FUNC_CAPTURE = 1'h1;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

endpackage

/* design/tcc_channel.sv */
// Timer compare/capture channel with APB register access.
// Assumes count_tick and capture_a_in are synchronous to clock.
//
// Function
// - Counter value readable, read-only, wraps from 0xFFFF to zero.
// - Capture A edge select, control bits 7:6, read-write, reset zero.
// - Output A waveform select, control bits 5:4, read-write, reset zero.
// - Control bit 1 inverts output A polarity, reset zero.
// - Control bit 0 picks compare or capture use of register A.
// - Sixteen-bit A register, read-write, reset zero, compare or captured.
// - Sixteen-bit B compare register, read-write, reset zero.
// - Interrupt enables for capture overwrite, capture, match B and match A, reset zero.
// - Flag bit 4 sets on capture overwrite, cleared by writing one.
// - Flag bit 2 sets on capture A, cleared by writing one or by reset.
// - Flag bit 1 sets on compare B match, cleared by writing one.
// - Flag bit 0 sets on compare A match, reset zero.
// - Reserved bits read zero; writes to them are discarded.
`timescale 1ns/10ps

module tcc_channel #(
   parameter int ADDR_W = 18,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer side
   input wire logic count_tick,
   input wire logic capture_a_in,
   output logic timer_output_a,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] count_value;
      logic [1:0] capture_a_edge_sel;
      logic [1:0] out_a_wave_sel;
      logic out_a_polarity;
      logic reg_a_function_sel;
      logic [CNT_W-1:0] match_capture_a_word;
      logic [CNT_W-1:0] match_b_word;
      logic cap_a_overrun_irq_en;
      logic cap_a_irq_en;
      logic match_b_irq_en;
      logic match_a_irq_en;
      logic cap_a_overrun_flag;
      logic cap_a_flag;
      logic match_b_flag;
      logic match_a_flag;
      logic wave_level;
      logic capture_prev;
      logic [15:0] read_word;
   } tcc_state_t;

   tcc_state_t state_q;
   tcc_state_t state_d;

   logic setup_phase;
   logic access_phase;
   logic [15:0] reg_index;
   logic hit_count;
   logic hit_ctl;
   logic hit_a;
   logic hit_b;
   logic hit_en;
   logic hit_flags;
   logic mapped;
   logic wr_ctl;
   logic wr_a;
   logic wr_b;
   logic wr_en;
   logic wr_flags;
   logic [15:0] wdata16;
   logic [CNT_W-1:0] count_next;
   logic rise_edge;
   logic fall_edge;
   logic capture_event;
   logic match_a_event;
   logic match_b_event;
   logic [15:0] flags_word;
   logic [15:0] enables_word;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------

   // Phases and word index from the byte address
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign reg_index = 16'(paddr >> tcc_pkg::WORD_SHIFT);
   assign wdata16 = pwdata[15:0];

   // Register hits
   assign hit_count = (reg_index == tcc_pkg::IDX_COUNTER_VALUE);
   assign hit_ctl = (reg_index == tcc_pkg::IDX_CAPTURE_CONTROL);
   assign hit_a = (reg_index == tcc_pkg::IDX_MATCH_CAPTURE_A);
   assign hit_b = (reg_index == tcc_pkg::IDX_MATCH_B);
   assign hit_en = (reg_index == tcc_pkg::IDX_INTERRUPT_ENABLES);
   assign hit_flags = (reg_index == tcc_pkg::IDX_INTERRUPT_FLAGS);
   assign mapped = hit_count || hit_ctl || hit_a || hit_b || hit_en
                   || hit_flags;

   // Writes take effect at the completing access edge
   assign wr_ctl = access_phase && pwrite && hit_ctl;
   assign wr_a = access_phase && pwrite && hit_a;
   assign wr_b = access_phase && pwrite && hit_b;
   assign wr_en = access_phase && pwrite && hit_en;
   assign wr_flags = access_phase && pwrite && hit_flags;

   // Zero wait states; unmapped accesses answer with an error
   assign pready = access_phase;
   assign pslverr = access_phase && !mapped;
   assign prdata = {16'h0000, state_q.read_word};

   // ----------------------------------------------------------------
   // Timer events
   // ----------------------------------------------------------------

   // Next count, wrapping past the top
   assign count_next = (state_q.count_value == tcc_pkg::COUNT_MAX) ?
                       tcc_pkg::RESET_WORD :
                       state_q.count_value + tcc_pkg::COUNT_STEP;

   // Edges of the capture input
   assign rise_edge = capture_a_in && !state_q.capture_prev;
   assign fall_edge = !capture_a_in && state_q.capture_prev;

   // Capture only in capture function with a selected edge
   always_comb
   begin
      capture_event = 1'b0;
      if (state_q.reg_a_function_sel == tcc_pkg::FUNC_CAPTURE)
      begin
         case (state_q.capture_a_edge_sel)
            tcc_pkg::EDGE_NONE: capture_event = 1'b0;
            tcc_pkg::EDGE_RISE: capture_event = rise_edge;
            tcc_pkg::EDGE_FALL: capture_event = fall_edge;
            tcc_pkg::EDGE_BOTH: capture_event = rise_edge || fall_edge;
            default: capture_event = 1'b0;
         endcase
      end
   end

   // Matches when the counter steps onto a compare value
   assign match_a_event = count_tick
                          && (state_q.reg_a_function_sel
                              == tcc_pkg::FUNC_COMPARE)
                          && (count_next
                              == state_q.match_capture_a_word);
   assign match_b_event = count_tick
                          && (count_next == state_q.match_b_word);

   // Packed flag and enable words, reserved bits zero
   always_comb
   begin
      flags_word = 16'h0000;
      flags_word[tcc_pkg::IRQ_OVR_BIT] = state_q.cap_a_overrun_flag;
      flags_word[tcc_pkg::IRQ_CAP_BIT] = state_q.cap_a_flag;
      flags_word[tcc_pkg::IRQ_MB_BIT] = state_q.match_b_flag;
      flags_word[tcc_pkg::IRQ_MA_BIT] = state_q.match_a_flag;
      enables_word = 16'h0000;
      enables_word[tcc_pkg::IRQ_OVR_BIT] = state_q.cap_a_overrun_irq_en;
      enables_word[tcc_pkg::IRQ_CAP_BIT] = state_q.cap_a_irq_en;
      enables_word[tcc_pkg::IRQ_MB_BIT] = state_q.match_b_irq_en;
      enables_word[tcc_pkg::IRQ_MA_BIT] = state_q.match_a_irq_en;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.capture_prev = capture_a_in;

      // Counter advance
      if (count_tick)
      begin
         state_d.count_value = count_next;
      end

      // Control register, reserved bits dropped
      if (wr_ctl)
      begin
         state_d.capture_a_edge_sel =
            wdata16[tcc_pkg::CTL_EDGE_LSB +: 2];
         state_d.out_a_wave_sel =
            wdata16[tcc_pkg::CTL_WAVE_LSB +: 2];
         state_d.out_a_polarity = wdata16[tcc_pkg::CTL_POL_BIT];
         state_d.reg_a_function_sel =
            wdata16[tcc_pkg::CTL_FUNC_BIT];
      end

      // A register: software write, captured count wins
      if (wr_a)
      begin
         state_d.match_capture_a_word = wdata16[CNT_W-1:0];
      end
      if (capture_event)
      begin
         state_d.match_capture_a_word = state_q.count_value;
      end

      // B register
      if (wr_b)
      begin
         state_d.match_b_word = wdata16[CNT_W-1:0];
      end

      // Interrupt enables
      if (wr_en)
      begin
         state_d.cap_a_overrun_irq_en =
            wdata16[tcc_pkg::IRQ_OVR_BIT];
         state_d.cap_a_irq_en = wdata16[tcc_pkg::IRQ_CAP_BIT];
         state_d.match_b_irq_en = wdata16[tcc_pkg::IRQ_MB_BIT];
         state_d.match_a_irq_en = wdata16[tcc_pkg::IRQ_MA_BIT];
      end

      // Write one to clear; zero leaves a flag alone
      if (wr_flags)
      begin
         if (wdata16[tcc_pkg::IRQ_OVR_BIT])
         begin
            state_d.cap_a_overrun_flag = 1'b0;
         end
         if (wdata16[tcc_pkg::IRQ_CAP_BIT])
         begin
            state_d.cap_a_flag = 1'b0;
         end
         if (wdata16[tcc_pkg::IRQ_MB_BIT])
         begin
            state_d.match_b_flag = 1'b0;
         end
         if (wdata16[tcc_pkg::IRQ_MA_BIT])
         begin
            state_d.match_a_flag = 1'b0;
         end
      end

      // Events set flags after the clear, so a set wins
      if (capture_event && state_q.cap_a_flag)
      begin
         state_d.cap_a_overrun_flag = 1'b1;
      end
      if (capture_event)
      begin
         state_d.cap_a_flag = 1'b1;
      end
      if (match_b_event)
      begin
         state_d.match_b_flag = 1'b1;
      end
      if (match_a_event)
      begin
         state_d.match_a_flag = 1'b1;
      end

      // Output A waveform
      case (state_q.out_a_wave_sel)
         tcc_pkg::WAVE_OFF: state_d.wave_level = 1'b0;
         tcc_pkg::WAVE_SET_A_CLR_B:
         begin
            if (match_a_event)
            begin
               state_d.wave_level = 1'b1;
            end
            else if (match_b_event)
            begin
               state_d.wave_level = 1'b0;
            end
         end
         tcc_pkg::WAVE_TOGGLE_A:
         begin
            if (match_a_event)
            begin
               state_d.wave_level = !state_q.wave_level;
            end
         end
         tcc_pkg::WAVE_TOGGLE_B:
         begin
            if (match_b_event)
            begin
               state_d.wave_level = !state_q.wave_level;
            end
         end
         default: state_d.wave_level = 1'b0;
      endcase

      // Read data captured in the setup cycle
      if (setup_phase && !pwrite)
      begin
         if (hit_count)
         begin
            state_d.read_word = state_q.count_value;
         end
         else if (hit_ctl)
         begin
            state_d.read_word = 16'h0000;
            state_d.read_word[tcc_pkg::CTL_EDGE_LSB +: 2] =
               state_q.capture_a_edge_sel;
            state_d.read_word[tcc_pkg::CTL_WAVE_LSB +: 2] =
               state_q.out_a_wave_sel;
            state_d.read_word[tcc_pkg::CTL_POL_BIT] = state_q.out_a_polarity;
            state_d.read_word[tcc_pkg::CTL_FUNC_BIT] =
               state_q.reg_a_function_sel;
         end
         else if (hit_a)
         begin
            state_d.read_word = state_q.match_capture_a_word;
         end
         else if (hit_b)
         begin
            state_d.read_word = state_q.match_b_word;
         end
         else if (hit_en)
         begin
            state_d.read_word = enables_word & tcc_pkg::IRQ_MASK;
         end
         else if (hit_flags)
         begin
            state_d.read_word = flags_word & tcc_pkg::IRQ_MASK;
         end
         else
         begin
            state_d.read_word = 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Polarity applied to the registered wave level
   assign timer_output_a = state_q.wave_level
                           ^ state_q.out_a_polarity;

   // Level interrupt from any enabled flag
   assign irq = |(flags_word & enables_word);

endmodule

/* verif/tcc_channel_asserts.sv */
// Checker for the compare/capture channel register and interrupt ports.
// Assumes it is bound to tcc_channel and sees only that module's ports.
`timescale 1ns/10ps
module tcc_channel_asserts #(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Timer side
   input wire logic count_tick,
   input wire logic capture_a_in,
   input wire logic timer_output_a,
   input wire logic irq
);
   // ---------------------------------------------------------------
   // Decode and shadow copies
   // ---------------------------------------------------------------
   logic [ADDR_W-3:0] idx;
   logic rd_acc, wr_acc, mapped;
   logic [15:0] ctl_q, b_q, en_q;
   // Access phase decode
   assign idx = paddr[ADDR_W-1:2];
   assign rd_acc = psel & penable & ~pwrite;
   assign wr_acc = psel & penable & pwrite;
   assign mapped = idx inside {tcc_pkg::IDX_COUNTER_VALUE,
      tcc_pkg::IDX_CAPTURE_CONTROL, tcc_pkg::IDX_MATCH_CAPTURE_A,
      tcc_pkg::IDX_MATCH_B, tcc_pkg::IDX_INTERRUPT_ENABLES,
      tcc_pkg::IDX_INTERRUPT_FLAGS};
   // Software-written values, reserved bits dropped
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctl_q <= 16'h0000;
         b_q <= 16'h0000;
         en_q <= 16'h0000;
      end
      else if (wr_acc)
      begin
         if (idx == tcc_pkg::IDX_CAPTURE_CONTROL)
            ctl_q <= pwdata[15:0] & 16'h00F3;
         if (idx == tcc_pkg::IDX_MATCH_B)
            b_q <= pwdata[15:0];
         if (idx == tcc_pkg::IDX_INTERRUPT_ENABLES)
            en_q <= pwdata[15:0] & tcc_pkg::IRQ_MASK;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_ctl_rd;
      rd_acc && idx == tcc_pkg::IDX_CAPTURE_CONTROL
         |-> prdata == {16'h0000, ctl_q};
   endproperty
   a_ctl_rd: assert property (p_ctl_rd)
      else $error("control readback");
   property p_b_rd;
      rd_acc && idx == tcc_pkg::IDX_MATCH_B |-> prdata[15:0] == b_q;
   endproperty
   a_b_rd: assert property (p_b_rd)
      else $error("match b readback");
   property p_en_rd;
      rd_acc && idx == tcc_pkg::IDX_INTERRUPT_ENABLES
         |-> prdata[15:0] == en_q;
   endproperty
   a_en_rd: assert property (p_en_rd)
      else $error("enable readback");
   property p_flag_rsv;
      rd_acc && idx == tcc_pkg::IDX_INTERRUPT_FLAGS
         |-> (prdata[15:0] & ~tcc_pkg::IRQ_MASK) == 16'h0000;
   endproperty
   a_flag_rsv: assert property (p_flag_rsv)
      else $error("flag spare bits");
   property p_unmapped;
      rd_acc && !mapped |-> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read");
   property p_irq_en;
      irq |-> en_q != 16'h0000;
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("irq without enable");
   property p_irq_off;
      wr_acc && idx == tcc_pkg::IDX_INTERRUPT_ENABLES
         && pwdata[15:0] == 16'h0000 |=> !irq [*2];
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq after disable");
   property p_w1c_zero;
      irq && wr_acc && idx == tcc_pkg::IDX_INTERRUPT_FLAGS
         && pwdata[15:0] == 16'h0000 |=> irq;
   endproperty
   a_w1c_zero: assert property (p_w1c_zero)
      else $error("zero write cleared");
   property p_pol;
      ctl_q[5:4] == 2'h0 && $stable(ctl_q)
         |-> timer_output_a == ctl_q[1];
   endproperty
   a_pol: assert property (p_pol)
      else $error("output polarity");
   c_irq: cover property ($rose(irq));
   c_err: cover property (rd_acc && !mapped);
   c_cap: cover property (wr_acc && idx == tcc_pkg::IDX_CAPTURE_CONTROL
      && pwdata[0]);
endmodule

bind tcc_channel tcc_channel_asserts #(.ADDR_W(ADDR_W)) tcc_channel_asserts_i (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
   .capture_a_in(capture_a_in), .timer_output_a(timer_output_a), .irq(irq));

/* verif/tcc_channel_tb.sv */
// Self-checking bench for the compare/capture channel.
// Assumes the APB slave and timer inputs are driven here directly.
`timescale 1ns/10ps
module tcc_channel_tb;
   // ---------------------------------------------------------------
   // Signals and instance
   // ---------------------------------------------------------------
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic count_tick = 1'b0;
   logic capture_a_in = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, timer_output_a, irq, err;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [15:0] regs [6] = '{tcc_pkg::IDX_COUNTER_VALUE,
      tcc_pkg::IDX_CAPTURE_CONTROL, tcc_pkg::IDX_MATCH_CAPTURE_A,
      tcc_pkg::IDX_MATCH_B, tcc_pkg::IDX_INTERRUPT_ENABLES,
      tcc_pkg::IDX_INTERRUPT_FLAGS};
   tcc_channel #(.ADDR_W(18), .CNT_W(16)) tcc_channel_i (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
      .capture_a_in(capture_a_in), .timer_output_a(timer_output_a),
      .irq(irq));
   // Free-running clock, 8 ns period
   initial
   begin
      forever #4 clock = ~clock;
   end
   // Hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         stop_test;
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer after an idle edge; read data lands in rd
   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(rd, exp);
   endtask
   task automatic tick;
      count_tick <= 1'b1;
      @(posedge clock);
      count_tick <= 1'b0;
      @(posedge clock);
   endtask
   task automatic edge_in(input logic v);
      capture_a_in <= v;
      repeat (2) @(posedge clock);
   endtask
   // Settled check of {irq, timer_output_a}
   task automatic pins(input logic [1:0] exp);
      @(negedge clock);
      check({30'h0, irq, timer_output_a}, {30'h0, exp});
      @(posedge clock);
   endtask
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      foreach (regs[i])
         rchk(regs[i], 32'h0000_0000);
      $display("test done: reset values");
      apb(1'b1, tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0002);
      apb(1'b1, tcc_pkg::IDX_MATCH_B, 32'h0000_0003);
      repeat (3) tick;
      rchk(tcc_pkg::IDX_COUNTER_VALUE, 32'h0000_0003);
      apb(1'b1, tcc_pkg::IDX_COUNTER_VALUE, 32'h0000_1234);
      rchk(tcc_pkg::IDX_COUNTER_VALUE, 32'h0000_0003);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0003);
      $display("test done: count and compare");
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0041);
      edge_in(1'b1);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0003);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0007);
      tick;
      edge_in(1'b0);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0003);
      edge_in(1'b1);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0004);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0017);
      $display("test done: capture and overwrite");
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_ENABLES, 32'h0000_0001);
      pins(2'b10);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0000);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0017);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0014);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0003);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_ENABLES, 32'h0000_0004);
      pins(2'b00);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_ENABLES, 32'h0000_0017);
      rchk(tcc_pkg::IDX_INTERRUPT_ENABLES, 32'h0000_0017);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_ENABLES, 32'h0000_0000);
      apb(1'b1, tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0003);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0000);
      $display("test done: interrupts");
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0002);
      pins(2'b01);
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_00F3);
      rchk(tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_00F3);
      apb(1'b1, tcc_pkg::IDX_MATCH_CAPTURE_A, 32'hFFFF_A5C3);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_A5C3);
      rchk(16'h5430, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      $display("test done: control and reserved bits");
      apb(1'b1, tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0005);
      apb(1'b1, tcc_pkg::IDX_MATCH_B, 32'h0000_0006);
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0010);
      tick;
      pins(2'b01);
      tick;
      pins(2'b00);
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0020);
      apb(1'b1, tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0007);
      tick;
      pins(2'b01);
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0030);
      apb(1'b1, tcc_pkg::IDX_MATCH_B, 32'h0000_0008);
      tick;
      pins(2'b00);
      $display("test done: output waveforms");
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_0081);
      edge_in(1'b0);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0008);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0007);
      apb(1'b1, tcc_pkg::IDX_CAPTURE_CONTROL, 32'h0000_00C1);
      tick;
      edge_in(1'b1);
      rchk(tcc_pkg::IDX_MATCH_CAPTURE_A, 32'h0000_0009);
      rchk(tcc_pkg::IDX_INTERRUPT_FLAGS, 32'h0000_0017);
      $display("test done: capture edges");
      stop_test;
   end
endmodule
